// ==== common/fsc_pkg.sv ====
// Package for the single/double format conversion block: operation codes and field constants.
package fsc_pkg;
	typedef enum logic [2:0] {
		FSC_OP_LOAD_SINGLE = 3'h0,
		FSC_OP_LOAD_DOUBLE = 3'h1,
		FSC_OP_STORE_SINGLE = 3'h2,
		FSC_OP_STORE_DOUBLE = 3'h3,
		FSC_OP_STORE_INT_WORD = 3'h4
	} fsc_op_e;
	localparam logic [7:0] SGL_EXP_MAX = 8'hff;
	localparam logic [7:0] SGL_EXP_ZERO = 8'h00;
	localparam logic [10:0] DBL_EXP_NODENORM = 11'h380;
	localparam logic [10:0] DBL_EXP_DENORM_MIN = 11'h36a;
	localparam logic [10:0] DBL_BIAS = 11'h3ff;
	// Biased double exponent of -126, the smallest single normal exponent.
	localparam logic [10:0] SGL_DENORM_EXP = 11'h381;
	localparam logic [4:0] BASE_GPR_ZERO = 5'h00;
	localparam int LATENCY = 2;
	localparam logic [1:0] LAT_BITS = 2'h2;
endpackage : fsc_pkg

// ==== dv/fsc_rf_model.sv ====
// Register file model that absorbs base register updates.
`timescale 1ns/1ps
module fsc_rf_model (
	input wire logic clk_sys,
	input wire logic we,
	input wire logic [4:0] idx,
	input wire logic [63:0] wdata
);
	logic [63:0] gpr_q [32];
	always_ff @(posedge clk_sys)
	begin
		if (we)
			gpr_q[idx] <= wdata;
	end
endmodule : fsc_rf_model

// ==== dv/testbench.sv ====
// Self-checking bench for the format conversion datapath.
`timescale 1ns/1ps
module testbench;
	typedef struct {int c; logic [63:0] d; logic [2:0] m; logic [4:0] g; logic [63:0] a;} fsc_x_s;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic in_valid = 1'b0;
	fsc_pkg::fsc_op_e in_op = fsc_pkg::FSC_OP_LOAD_SINGLE;
	logic [63:0] in_data = 64'h0;
	logic in_update = 1'b0;
	logic [4:0] in_base_gpr = 5'h00;
	logic [63:0] in_effective_addr = 64'h0;
	logic out_valid, out_is_load, out_invalid_form, out_base_gpr_we;
	logic [63:0] out_data, out_base_gpr_data, d, la;
	logic [4:0] out_base_gpr, lg;
	logic [31:0] lf = 32'h23;
	logic [7:0] ek [8] = '{8'h00, 8'h01, 8'hfe, 8'hff, 8'h00, 8'h7f, 8'h00, 8'h80};
	logic [10:0] es [8] = '{11'h369, 11'h36a, 11'h380, 11'h381, 11'h47f, 11'h000, 11'h375, 11'h7ff};
	int n_errors = 0;
	int compares = 0;
	int cnt = 0;
	fsc_x_s q [$];
	fsc_x_s x;
	fsc_convert i_dut (.clk_sys(clk_sys), .rst(rst), .in_valid(in_valid), .in_op(in_op),
		.in_data(in_data), .in_update(in_update), .in_base_gpr(in_base_gpr),
		.in_effective_addr(in_effective_addr), .out_valid(out_valid), .out_data(out_data),
		.out_is_load(out_is_load), .out_invalid_form(out_invalid_form),
		.out_base_gpr_we(out_base_gpr_we), .out_base_gpr(out_base_gpr),
		.out_base_gpr_data(out_base_gpr_data));
	fsc_rf_model i_rf (.clk_sys(clk_sys), .we(out_base_gpr_we), .idx(out_base_gpr),
		.wdata(out_base_gpr_data));
	always #5 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [63:0] ld_s(input logic [31:0] w);
		logic [52:0] f;
		int e;
		f = {1'b0, w[22:0], 29'h0};
		e = -126;
		if (w[30:23] != 8'h00 && w[30:23] != 8'hff)
			return {w[31:30], {3{~w[30]}}, w[29:0], 29'h0};
		if (w[30:0] == 31'h0 || w[30:23] == 8'hff)
			return {w[31:30], {3{w[30]}}, w[29:0], 29'h0};
		while (!f[52])
		begin
			f = f << 1;
			e--;
		end
		return {w[31], 11'(e + 1023), f[51:0]};
	endfunction : ld_s
	// Stores below the denormal range write zero, the value chosen for the undefined case.
	function automatic logic [63:0] st_s(input logic [63:0] v);
		logic [52:0] f;
		int e;
		e = int'(v[62:52]) - 1023;
		f = {1'b1, v[51:0]};
		if (v[62:52] > 11'h380 || v[62:0] == 63'h0)
			return {32'h0, v[63:62], v[58:29]};
		if (v[62:52] < 11'h36a)
			return 64'h0;
		while (e < -126)
		begin
			f = f >> 1;
			e++;
		end
		return {32'h0, v[63], 8'h00, f[51:29]};
	endfunction : st_s
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic issue(input fsc_pkg::fsc_op_e op, input logic [63:0] v);
		logic ld;
		ld = op < fsc_pkg::FSC_OP_STORE_SINGLE;
		@(posedge clk_sys);
		in_valid <= 1'b1;
		in_op <= op;
		in_data <= v;
		in_update <= lf[6];
		in_base_gpr <= lf[7] ? lf[4:0] : 5'h00;
		in_effective_addr <= {lf, ~lf};
		x.c = cnt + fsc_pkg::LATENCY;
		x.d = op == fsc_pkg::FSC_OP_LOAD_SINGLE ? ld_s(v[31:0]) :
			op == fsc_pkg::FSC_OP_STORE_SINGLE ? st_s(v) : v;
		x.g = lf[7] ? lf[4:0] : 5'h00;
		x.m = {ld, ld & lf[6] & (x.g == 5'h00), ld & lf[6] & (x.g != 5'h00)};
		x.a = {lf, ~lf};
		if (x.m[0])
			{lg, la} = {x.g, x.a};
		q.push_back(x);
		lf = lfsr(lf);
	endtask : issue
	always @(negedge clk_sys)
	begin
		chk({63'h0, out_valid}, {63'h0, q.size() > 0 && q[0].c == cnt});
		if (out_valid === 1'b1 && q.size() > 0)
		begin
			x = q.pop_front();
			chk(out_data, x.d);
			chk({out_is_load, out_invalid_form, out_base_gpr_we}, x.m);
			if (x.m[0])
				chk({out_base_gpr, out_base_gpr_data}, {x.g, x.a});
		end
		cnt <= cnt + 1;
	end
	task automatic test_done();
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		$display("test reset done");
		for (int i = 0; i < 2000; i++)
		begin
			d = {lfsr(lf), lf};
			d[30:23] = ek[lf[13:11]];
			d[62:52] = es[lf[13:11]];
			if (lf[13:11] == 3'h6)
				d[22:0] = 23'h1;
			if (lf[13:11] == 3'h7)
				d = {d[63], 31'h0, d[31], 31'h0};
			issue(fsc_pkg::fsc_op_e'(3'(lf[10:8] % 3'h5)), d);
		end
		@(posedge clk_sys);
		in_valid <= 1'b0;
		for (int j = 0; j < 20 && q.size() > 0; j++)
			@(posedge clk_sys);
		if (q.size() > 0)
			chk(64'h1, 64'h0);
		// The last base write lands at the edge that ends the drain, so let it settle.
		@(negedge clk_sys);
		chk(i_rf.gpr_q[lg], la);
		$display("test mixed traffic done");
		test_done();
	end
endmodule : testbench

// ==== hdl/fsc_convert.sv ====
// Load/store format conversion datapath between memory words and the fp register file.
`timescale 1ns/1ps
module fsc_convert (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic in_valid,
	input wire fsc_pkg::fsc_op_e in_op,
	input wire logic [63:0] in_data,
	input wire logic in_update,
	input wire logic [4:0] in_base_gpr,
	input wire logic [63:0] in_effective_addr,
	output logic out_valid,
	output logic [63:0] out_data,
	output logic out_is_load,
	output logic out_invalid_form,
	output logic out_base_gpr_we,
	output logic [4:0] out_base_gpr,
	output logic [63:0] out_base_gpr_data
);
	////////////////////////////////////////////////////////////////////////
	// Stage 1: classify and shift. Field bit 0 is the sign, which sits at bit 31 or 63 here.
	logic [31:0] word;
	logic [7:0] s_exp;
	logic [52:0] ld_frac;
	logic [5:0] ld_lz;
	logic [10:0] d_exp;
	logic [52:0] st_frac;
	logic [5:0] st_amt;
	logic [52:0] st_shifted;
	logic [63:0] res;
	logic [10:0] ld_exp;

	assign word = in_data[31:0];
	assign s_exp = word[30:23];
	assign d_exp = in_data[62:52];
	assign ld_frac = {1'b0, word[22:0], 29'h0};
	assign st_frac = {1'b1, in_data[51:0]};
	// Right shift count is 897 - field: one at 896, up to 23 at 874.
	// Outside that range the count is junk, but the shifted value is then not selected.
	assign st_amt = 6'(fsc_pkg::SGL_DENORM_EXP - d_exp);

	fsc_shift u_shift (
		.lz_in(ld_frac),
		.lz_count(ld_lz),
		.rs_in(st_frac),
		.rs_amt(st_amt),
		.rs_out(st_shifted)
	);

	// Exponent -126 minus shift count, plus 1023: 897 - lz.
	assign ld_exp = fsc_pkg::SGL_DENORM_EXP - 11'(ld_lz);

	always_comb
	begin
		res = in_data;
		unique case (in_op)
			fsc_pkg::FSC_OP_LOAD_SINGLE:
			begin
				if (s_exp == fsc_pkg::SGL_EXP_ZERO && word[22:0] != 23'h0)
				begin
					// Left shift keeps the hidden one out of the stored fraction.
					res = {word[31], ld_exp, 52'(ld_frac << ld_lz)};
				end
				else if (s_exp == fsc_pkg::SGL_EXP_MAX || word[30:0] == 31'h0)
				begin
					res = {word[31:30], {3{word[30]}}, word[29:0], 29'h0};
				end
				else
				begin
					res = {word[31:30], {3{~word[30]}}, word[29:0], 29'h0};
				end
			end
			fsc_pkg::FSC_OP_STORE_SINGLE:
			begin
				// Overlarge values fall into the plain copy, which is well defined.
				if (d_exp > fsc_pkg::DBL_EXP_NODENORM || in_data[62:0] == 63'h0)
				begin
					res = {32'h0, in_data[63:62], in_data[58:29]};
				end
				else if (d_exp >= fsc_pkg::DBL_EXP_DENORM_MIN)
				begin
					res = {32'h0, in_data[63], fsc_pkg::SGL_EXP_ZERO, st_shifted[51:29]};
				end
				else
				begin
					// Any value is legal here; zero is cheapest.
					res = 64'h0;
				end
			end
			default:
			begin
				res = in_data;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Two-stage pipeline for fixed latency.
	// Control bits ride next to the data, so the register file sees them in the same cycle.
	logic [1:0] v_q;
	logic [63:0] d1_q, d2_q;
	logic [1:0] ld_q, inv_q, we_q;
	logic [4:0] g1_q, g2_q;
	logic [63:0] a1_q, a2_q;
	logic is_load, upd_ok;

	assign is_load = in_op == fsc_pkg::FSC_OP_LOAD_SINGLE || in_op == fsc_pkg::FSC_OP_LOAD_DOUBLE;
	assign upd_ok = in_valid && is_load && in_update && in_base_gpr != fsc_pkg::BASE_GPR_ZERO;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			v_q <= 2'h0;
			ld_q <= 2'h0;
			inv_q <= 2'h0;
			we_q <= 2'h0;
		end
		else
		begin
			v_q <= {v_q[0], in_valid};
			ld_q <= {ld_q[0], is_load};
			we_q <= {we_q[0], upd_ok};
			inv_q <= {inv_q[0], in_valid && is_load && in_update && !upd_ok};
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			d1_q <= 64'h0;
			d2_q <= 64'h0;
			g1_q <= 5'h00;
			g2_q <= 5'h00;
			a1_q <= 64'h0;
			a2_q <= 64'h0;
		end
		else
		begin
			d1_q <= res;
			d2_q <= d1_q;
			g1_q <= in_base_gpr;
			g2_q <= g1_q;
			a1_q <= in_effective_addr;
			a2_q <= a1_q;
		end
	end

	assign out_valid = v_q[1];
	assign out_data = d2_q;
	assign out_is_load = ld_q[1];
	assign out_base_gpr_we = we_q[1];
	assign out_invalid_form = inv_q[1];
	assign out_base_gpr = g2_q;
	assign out_base_gpr_data = a2_q;

	////////////////////////////////////////////////////////////////////////
	latency_fixed_a: assert property (@(posedge clk_sys) disable iff (rst)
		in_valid |-> ##2 out_valid) else $error("valid lost in pipe");
	idle_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
		!in_valid |-> ##2 !out_valid) else $error("result without request");
	double_pass_a: assert property (@(posedge clk_sys) disable iff (rst)
		in_valid && in_op == fsc_pkg::FSC_OP_LOAD_DOUBLE |-> ##2 out_data == $past(in_data, 2))
		else $error("double load altered");
	store_pass_a: assert property (@(posedge clk_sys) disable iff (rst)
		in_valid && in_op == fsc_pkg::FSC_OP_STORE_DOUBLE |-> ##2 out_data == $past(in_data, 2))
		else $error("double store altered");
	int_word_a: assert property (@(posedge clk_sys) disable iff (rst)
		in_valid && in_op == fsc_pkg::FSC_OP_STORE_INT_WORD |-> ##2 out_data == $past(in_data, 2))
		else $error("integer word store altered");
	base_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
		in_valid && in_update && in_base_gpr == 5'h00 |-> ##2 !out_base_gpr_we)
		else $error("base zero written");
	invalid_form_a: assert property (@(posedge clk_sys) disable iff (rst)
		in_valid && is_load && in_update && in_base_gpr == fsc_pkg::BASE_GPR_ZERO
		|-> ##2 out_invalid_form) else $error("invalid form not flagged");
	store_update_a: assert property (@(posedge clk_sys) disable iff (rst)
		in_valid && !is_load |-> ##2 !out_base_gpr_we && !out_invalid_form)
		else $error("store touched base register");
	base_write_a: assert property (@(posedge clk_sys) disable iff (rst)
		upd_ok |-> ##2 out_base_gpr_we && out_base_gpr_data == $past(in_effective_addr, 2))
		else $error("base update wrong");
	load_normal_a: assert property (@(posedge clk_sys) disable iff (rst)
		in_valid && in_op == fsc_pkg::FSC_OP_LOAD_SINGLE && s_exp != 8'h00 && s_exp != 8'hff
		|-> ##2 out_data[61:59] == {3{~$past(word[30], 2)}} && out_data[28:0] == 29'h0)
		else $error("normal load fill wrong");
	load_special_a: assert property (@(posedge clk_sys) disable iff (rst)
		in_valid && in_op == fsc_pkg::FSC_OP_LOAD_SINGLE && s_exp == 8'hff
		|-> ##2 out_data[62:52] == 11'h7ff) else $error("inf load wrong");
	load_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
		in_valid && in_op == fsc_pkg::FSC_OP_LOAD_SINGLE && word[30:0] == 31'h0
		|-> ##2 out_data[62:0] == 63'h0) else $error("zero load not zero");
	load_denorm_a: assert property (@(posedge clk_sys) disable iff (rst)
		in_valid && in_op == fsc_pkg::FSC_OP_LOAD_SINGLE && s_exp == 8'h00 && word[22]
		|-> ##2 out_data[62:52] == 11'h380) else $error("denormal exponent wrong");
	store_copy_a: assert property (@(posedge clk_sys) disable iff (rst)
		in_valid && in_op == fsc_pkg::FSC_OP_STORE_SINGLE && d_exp > fsc_pkg::DBL_EXP_NODENORM
		|-> ##2 out_data == {32'h0, $past(in_data[63:62], 2), $past(in_data[58:29], 2)})
		else $error("plain store copy wrong");
	store_denorm_a: assert property (@(posedge clk_sys) disable iff (rst)
		in_valid && in_op == fsc_pkg::FSC_OP_STORE_SINGLE && d_exp == 11'h380
		|-> ##2 out_data[30:0] == {8'h00, 1'b1, $past(in_data[51:30], 2)})
		else $error("denormal store wrong");
	// The deepest denormal keeps only the hidden one, in the last fraction bit.
	store_deep_a: assert property (@(posedge clk_sys) disable iff (rst)
		in_valid && in_op == fsc_pkg::FSC_OP_STORE_SINGLE && d_exp == fsc_pkg::DBL_EXP_DENORM_MIN
		|-> ##2 out_data[30:0] == {8'h00, 23'h1}) else $error("deepest denormal store wrong");
endmodule : fsc_convert

// ==== hdl/fsc_shift.sv ====
// Priority-encoded shifter: leading-zero count of a 53-bit fraction and a right shift.
`timescale 1ns/1ps
module fsc_shift (
	input wire logic [52:0] lz_in,
	output logic [5:0] lz_count,
	input wire logic [52:0] rs_in,
	input wire logic [5:0] rs_amt,
	output logic [52:0] rs_out
);
	always_comb
	begin
		lz_count = 6'h00;
		for (int i = 0; i <= 52; i++)
		begin
			if (lz_in[i])
			begin
				lz_count = 6'(52 - i);
			end
		end
	end

	assign rs_out = rs_in >> rs_amt;
endmodule : fsc_shift
